// ### hw/mis_cfg.svh
// offsets, field positions and reset values of the status flag block
//
// Contract
// - sag on phase A/B/C sets bits 3-5
// - missing phase crossing sets bits 6-8
// - rising zero crossing per phase sets 9-11
// - line-cycle accumulation done sets bit 12
// - bit 13 defaults 1, high one cycle only
// - supply-low event restores every register default
// - voltage above its threshold sets bit 14
// - current above its threshold sets bit 15
// - new waveform sample sets bit 16
// - selected-phase active sign change sets 17
// - selected-phase reactive sign change sets 18
// - A crossing then B, not C, sets 19
// - interrupt low only for set, unmasked flags
// - flags sticky until clearing-view read
// - energy half-full flags on bits 0-2
`ifndef MIS_CFG_SVH
`define MIS_CFG_SVH

// register word indices; byte address is four times the index
`define MIS_IDX_CALCMODE 6'h13
`define MIS_IDX_MASK     6'h18
`define MIS_IDX_STATUS   6'h19
`define MIS_IDX_CLRVIEW  6'h1a
`define MIS_IDX_HALFCYC  6'h1c
`define MIS_IDX_VPEAK    6'h1d
`define MIS_IDX_IPEAK    6'h1e

// flag bit positions
`define MIS_BIT_ACTHALF  0
`define MIS_BIT_RCTHALF  1
`define MIS_BIT_APPHALF  2
`define MIS_BIT_SAG      3
`define MIS_BIT_ZXTO     6
`define MIS_BIT_ZX       9
`define MIS_BIT_LINE     12
`define MIS_BIT_RESET    13
`define MIS_BIT_VPEAK    14
`define MIS_BIT_IPEAK    15
`define MIS_BIT_WAVE     16
`define MIS_BIT_REVP     17
`define MIS_BIT_REVQ     18
`define MIS_BIT_SEQ      19

// computation mode fields
`define MIS_CM_SEL_LSB   0
`define MIS_CM_LINE_BIT  3

// reset values, plus the writable-bit mask of the mask register
`define MIS_FLAGS_RST    20'h02000
`define MIS_MASK_RST     20'h00000
`define MIS_MASK_WR      20'hfdfff
`define MIS_CM_RST       4'h7
`define MIS_HALFCYC_RST  16'hffff
`define MIS_VPEAK_RST    24'hffffff
`define MIS_IPEAK_RST    24'hffffff

`endif

// ### hw/mis_pkg.sv
// types shared by the status flag block
package mis_pkg;
  typedef logic [19:0] mis_flags_t;
  typedef logic [2:0]  mis_phase_t;
  typedef enum logic [1:0] {
    MIS_SEQ_IDLE  = 2'b00,
    MIS_SEQ_AFTER = 2'b01
  } mis_seq_state_t;
endpackage : mis_pkg

// ### hw/mis_evt_if.sv
// carrier between flag logic and sequence/line-cycle detector
`timescale 1ns/100ps
interface mis_evt_if;
  mis_pkg::mis_phase_t crossRise;      // rising zero crossing pulses
  logic                halfCycleTick;  // half line cycle pulse
  logic                lineModeEn;     // line-cycle accumulation on
  logic [15:0]         halfCycleCount; // programmed half cycles
  logic                swReset;        // supply-low reset event
  logic                seqErrEvent;    // phase order error pulse
  logic                lineDoneEvent;  // accumulation done pulse
  modport ctrl (
    output crossRise, halfCycleTick, lineModeEn, halfCycleCount, swReset,
    input  seqErrEvent, lineDoneEvent
  );
  modport det (
    input  crossRise, halfCycleTick, lineModeEn, halfCycleCount, swReset,
    output seqErrEvent, lineDoneEvent
  );
endinterface : mis_evt_if

// ### hw/mis_seq_line.sv
// phase order checker and line-cycle accumulation counter
`timescale 1ns/100ps
`include "mis_cfg.svh"
module mis_seq_line (
  input wire logic mclk,    // 25 MHz clock
  input wire logic reset_n, // async reset, active low
  mis_evt_if.det   evt      // events in, detections out
);
  mis_pkg::mis_seq_state_t seqState_reg;
  logic [15:0]             halfCount_reg;

  // after an A crossing, a B crossing before the C one is an order error
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      seqState_reg    <= mis_pkg::MIS_SEQ_IDLE;
      evt.seqErrEvent <= 1'b0;
    end else if (evt.swReset) begin
      seqState_reg    <= mis_pkg::MIS_SEQ_IDLE;
      evt.seqErrEvent <= 1'b0;
    end else begin
      evt.seqErrEvent <= 1'b0;
      unique case (seqState_reg)
        mis_pkg::MIS_SEQ_IDLE: begin
          if (evt.crossRise[0]) begin
            seqState_reg <= mis_pkg::MIS_SEQ_AFTER;
          end
        end
        mis_pkg::MIS_SEQ_AFTER: begin
          if (evt.crossRise[1]) begin
            evt.seqErrEvent <= 1'b1;
            seqState_reg    <= mis_pkg::MIS_SEQ_IDLE;
          end else if (evt.crossRise[2]) begin
            seqState_reg <= mis_pkg::MIS_SEQ_IDLE;
          end
        end
        default: seqState_reg <= mis_pkg::MIS_SEQ_IDLE;
      endcase
    end
  end

  // count of zero wraps the sum, so it completes after 65536 half cycles
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      halfCount_reg     <= 16'h0000;
      evt.lineDoneEvent <= 1'b0;
    end else if (evt.swReset || !evt.lineModeEn) begin
      halfCount_reg     <= 16'h0000;
      evt.lineDoneEvent <= 1'b0;
    end else begin
      evt.lineDoneEvent <= 1'b0;
      if (evt.halfCycleTick) begin
        if (halfCount_reg + 16'h0001 == evt.halfCycleCount) begin
          halfCount_reg     <= 16'h0000;
          evt.lineDoneEvent <= 1'b1;
        end else begin
          halfCount_reg <= halfCount_reg + 16'h0001;
        end
      end
    end
  end
endmodule : mis_seq_line

// ### hw/mis_status_flags.sv
// interrupt status flags with classic wishbone register access
`timescale 1ns/100ps
`include "mis_cfg.svh"
module mis_status_flags (
  input  wire logic        mclk,          // 25 MHz clock
  input  wire logic        reset_n,       // async reset, active low
  // wishbone classic slave
  input  wire logic        wb_cyc_i,      // bus cycle
  input  wire logic        wb_stb_i,      // strobe
  input  wire logic        wb_we_i,       // write enable
  input  wire logic [7:0]  wb_adr_i,      // byte address
  input  wire logic [3:0]  wb_sel_i,      // byte lanes
  input  wire logic [31:0] wb_dat_i,      // write data
  output logic      [31:0] wb_dat_o,      // read data
  output logic             wb_ack_o,      // acknowledge
  // interrupt
  output logic             irqN,          // interrupt, active low
  // measurement events
  input  wire logic [2:0]  sagEvent,      // sag pulse per phase
  input  wire logic [2:0]  crossTimeout,  // missing crossing pulse
  input  wire logic [2:0]  crossRise,     // rising crossing pulse
  input  wire logic        halfCycleTick, // half line cycle pulse
  input  wire logic        supplyLow,     // supply below 4 V level
  input  wire logic [23:0] voltageSample, // selected voltage magnitude
  input  wire logic [23:0] currentSample, // selected current magnitude
  input  wire logic        waveReady,     // new waveform sample pulse
  input  wire logic [2:0]  activeSign,    // active power sign per phase
  input  wire logic [2:0]  reactiveSign,  // reactive power sign
  input  wire logic [2:0]  activeBit14,   // active accumulators bit 14
  input  wire logic [2:0]  reactiveBit14, // reactive accumulators bit 14
  input  wire logic [2:0]  apparentBit15  // apparent accumulators bit 15
);

  // flags and software registers
  mis_pkg::mis_flags_t flags_reg;
  mis_pkg::mis_flags_t flags_next;
  mis_pkg::mis_flags_t mask_reg;
  logic [3:0]          computation_mode_reg_reg;
  logic [15:0]         halfCycles_reg;
  logic [23:0]         vPeakThr_reg;
  logic [23:0]         iPeakThr_reg;

  // history for edge and change detection
  logic                supplyLowPrev_reg;
  logic [2:0]          activeSignPrev_reg;
  logic [2:0]          reactiveSignPrev_reg;
  logic [2:0]          activeBitPrev_reg;
  logic [2:0]          reactiveBitPrev_reg;
  logic [2:0]          apparentBitPrev_reg;

  // bus decode
  logic [5:0]          regIdx;
  logic                busReq;
  logic                wrStrobe;
  logic                clrRead;
  logic [31:0]         readMux;
  mis_pkg::mis_flags_t clrBits;
  mis_pkg::mis_flags_t evtBits;
  logic                resetEvent;

  mis_evt_if evtBus ();

  function automatic logic [2:0] changeOf(input logic [2:0] now,
                                          input logic [2:0] prev);
    changeOf = now ^ prev;
  endfunction : changeOf

  function automatic logic [2:0] riseOf(input logic [2:0] now,
                                        input logic [2:0] prev);
    riseOf = now & ~prev;
  endfunction : riseOf

  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] wr,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wr[8*b +: 8];
      end
    end
    laneMerge = res;
  endfunction : laneMerge

  assign regIdx   = wb_adr_i[7:2];
  assign busReq   = wb_cyc_i && wb_stb_i;
  // write lands on the edge where ack is seen high
  assign wrStrobe = busReq && wb_we_i && wb_ack_o;
  assign clrRead  = busReq && !wb_we_i && wb_ack_o &&
                    regIdx == `MIS_IDX_CLRVIEW;
  // clear only what was returned, so late events survive the read
  assign clrBits  = clrRead ? wb_dat_o[19:0] : '0;

  assign resetEvent = supplyLow && !supplyLowPrev_reg;

  // detector submodule link
  assign evtBus.crossRise      = crossRise;
  assign evtBus.halfCycleTick  = halfCycleTick;
  assign evtBus.lineModeEn     = computation_mode_reg_reg[`MIS_CM_LINE_BIT];
  assign evtBus.halfCycleCount = halfCycles_reg;
  assign evtBus.swReset        = resetEvent;

  mis_seq_line seqLine (
    .mclk    (mclk),
    .reset_n (reset_n),
    .evt     (evtBus)
  );

  // event vector, one bit per flag
  always_comb begin
    evtBits = '0;
    evtBits[`MIS_BIT_ACTHALF] =
      |changeOf(activeBit14, activeBitPrev_reg);
    evtBits[`MIS_BIT_RCTHALF] =
      |changeOf(reactiveBit14, reactiveBitPrev_reg);
    evtBits[`MIS_BIT_APPHALF] =
      |riseOf(apparentBit15, apparentBitPrev_reg);
    evtBits[`MIS_BIT_SAG +: 3]  = sagEvent;
    evtBits[`MIS_BIT_ZXTO +: 3] = crossTimeout;
    evtBits[`MIS_BIT_ZX +: 3]   = crossRise;
    evtBits[`MIS_BIT_LINE]      = evtBus.lineDoneEvent;
    evtBits[`MIS_BIT_VPEAK] = voltageSample > vPeakThr_reg;
    evtBits[`MIS_BIT_IPEAK] = currentSample > iPeakThr_reg;
    evtBits[`MIS_BIT_WAVE] = waveReady;
    evtBits[`MIS_BIT_REVP] =
      |(changeOf(activeSign, activeSignPrev_reg) &
        computation_mode_reg_reg[`MIS_CM_SEL_LSB +: 3]);
    evtBits[`MIS_BIT_REVQ] =
      |(changeOf(reactiveSign, reactiveSignPrev_reg) &
        computation_mode_reg_reg[`MIS_CM_SEL_LSB +: 3]);
    evtBits[`MIS_BIT_SEQ]  = evtBus.seqErrEvent;
  end

  // set wins over clear; a set flag stays set, except bit 13, which drops the next cycle
  always_comb begin
    if (resetEvent) begin
      flags_next = `MIS_FLAGS_RST;
    end else begin
      flags_next = (flags_reg & ~clrBits) | evtBits;
      flags_next[`MIS_BIT_RESET] = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= `MIS_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // history for sign and accumulator bit changes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      supplyLowPrev_reg    <= 1'b0;
      activeSignPrev_reg   <= 3'h0;
      reactiveSignPrev_reg <= 3'h0;
      activeBitPrev_reg    <= 3'h0;
      reactiveBitPrev_reg  <= 3'h0;
      apparentBitPrev_reg  <= 3'h0;
    end else begin
      supplyLowPrev_reg    <= supplyLow;
      activeSignPrev_reg   <= activeSign;
      reactiveSignPrev_reg <= reactiveSign;
      activeBitPrev_reg    <= activeBit14;
      reactiveBitPrev_reg  <= reactiveBit14;
      apparentBitPrev_reg  <= apparentBit15;
    end
  end

  // software registers; supply-low event reloads defaults
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= `MIS_MASK_RST;
    end else if (resetEvent) begin
      mask_reg <= `MIS_MASK_RST;
    end else if (wrStrobe && regIdx == `MIS_IDX_MASK) begin
      mask_reg <= 20'(laneMerge({12'h000, mask_reg}, wb_dat_i,
                                wb_sel_i)) & `MIS_MASK_WR;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      computation_mode_reg_reg <= `MIS_CM_RST;
    end else if (resetEvent) begin
      computation_mode_reg_reg <= `MIS_CM_RST;
    end else if (wrStrobe && regIdx == `MIS_IDX_CALCMODE) begin
      computation_mode_reg_reg <= 4'(laneMerge({28'h0000000, computation_mode_reg_reg}, wb_dat_i,
                                   wb_sel_i));
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      halfCycles_reg <= `MIS_HALFCYC_RST;
    end else if (resetEvent) begin
      halfCycles_reg <= `MIS_HALFCYC_RST;
    end else if (wrStrobe && regIdx == `MIS_IDX_HALFCYC) begin
      halfCycles_reg <= 16'(laneMerge({16'h0000, halfCycles_reg}, wb_dat_i,
                                      wb_sel_i));
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vPeakThr_reg <= `MIS_VPEAK_RST;
      iPeakThr_reg <= `MIS_IPEAK_RST;
    end else if (resetEvent) begin
      vPeakThr_reg <= `MIS_VPEAK_RST;
      iPeakThr_reg <= `MIS_IPEAK_RST;
    end else if (wrStrobe && regIdx == `MIS_IDX_VPEAK) begin
      vPeakThr_reg <= 24'(laneMerge({8'h00, vPeakThr_reg}, wb_dat_i,
                                    wb_sel_i));
    end else if (wrStrobe && regIdx == `MIS_IDX_IPEAK) begin
      iPeakThr_reg <= 24'(laneMerge({8'h00, iPeakThr_reg}, wb_dat_i,
                                    wb_sel_i));
    end
  end

  // read data; unmapped words read as zero
  always_comb begin
    readMux = 32'h00000000;
    unique case (regIdx)
      `MIS_IDX_CALCMODE: readMux = {28'h0000000, computation_mode_reg_reg};
      `MIS_IDX_MASK:     readMux = {12'h000, mask_reg};
      `MIS_IDX_STATUS:   readMux = {12'h000, flags_reg};
      `MIS_IDX_CLRVIEW:  readMux = {12'h000, flags_reg};
      `MIS_IDX_HALFCYC:  readMux = {16'h0000, halfCycles_reg};
      `MIS_IDX_VPEAK:    readMux = {8'h00, vPeakThr_reg};
      `MIS_IDX_IPEAK:    readMux = {8'h00, iPeakThr_reg};
      default:           readMux = 32'h00000000;
    endcase
  end

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq && !wb_ack_o;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (busReq && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= readMux;
    end
  end

  // mask bit 13 is reserved and never writable, so reset pulse stays quiet
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irqN <= 1'b1;
    end else begin
      irqN <= ~|(flags_next & mask_reg);
    end
  end

endmodule : mis_status_flags

// ### sim/mis_mcu_model.sv
// wishbone classic master standing in for the microcontroller
`timescale 1ns/100ps
module mis_mcu_model (
  input  wire logic        mclk,     // clock
  input  wire logic        reset_n,  // async reset, active low
  input  wire logic        go,       // start one access
  input  wire logic        goWe,     // access is a write
  input  wire logic [7:0]  goAdr,    // byte address
  input  wire logic [31:0] goDat,    // write data
  output logic             done,     // access over, one cycle
  output logic      [31:0] rdData,   // data taken at ack
  output logic             wb_cyc_i, // bus cycle
  output logic             wb_stb_i, // strobe
  output logic             wb_we_i,  // write enable
  output logic      [7:0]  wb_adr_i, // byte address
  output logic      [3:0]  wb_sel_i, // byte lanes
  output logic      [31:0] wb_dat_i, // write data
  input  wire logic        wb_ack_o, // acknowledge
  input  wire logic [31:0] wb_dat_o  // read data
);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {wb_cyc_i, wb_stb_i, wb_we_i, done} <= 4'h0;
      {wb_adr_i, wb_sel_i, wb_dat_i, rdData} <= '0;
    end else if (wb_cyc_i && wb_ack_o) begin
      {wb_cyc_i, wb_stb_i, done} <= 3'h1;
      // released lines flip so a stale value never looks valid
      wb_we_i  <= ~wb_we_i;
      wb_adr_i <= ~wb_adr_i;
      wb_dat_i <= ~wb_dat_i;
      rdData   <= wb_dat_o;
    end else begin
      done <= 1'b0;
      if (go && !wb_cyc_i) begin
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, goWe};
        wb_adr_i <= goAdr;
        wb_dat_i <= goDat;
        wb_sel_i <= 4'hf;
      end
    end
  end
endmodule : mis_mcu_model

// ### sim/mis_status_flags_sva.sv
// concurrent checks on the status flag block ports
`timescale 1ns/100ps
`include "mis_cfg.svh"
module mis_status_flags_sva (
  input wire logic        mclk,         // clock
  input wire logic        reset_n,      // async reset, active low
  input wire logic        wb_cyc_i,     // bus cycle
  input wire logic        wb_stb_i,     // strobe
  input wire logic        wb_we_i,      // write enable
  input wire logic [7:0]  wb_adr_i,     // byte address
  input wire logic [3:0]  wb_sel_i,     // byte lanes
  input wire logic [31:0] wb_dat_i,     // write data
  input wire logic        wb_ack_o,     // acknowledge
  input wire logic        irqN,         // interrupt, active low
  input wire logic [2:0]  sagEvent,     // sag pulses
  input wire logic [2:0]  crossTimeout, // missing crossing pulses
  input wire logic [2:0]  crossRise,    // rising crossing pulses
  input wire logic        supplyLow     // supply-low level
);
  logic [19:0] maskSh;
  logic [19:0] lanes;
  logic        supPrev;
  logic        maskWr;
  logic        clrAck;
  logic        rstEvt;
  assign rstEvt = supplyLow && !supPrev;
  assign lanes  = {{4{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign maskWr = wb_ack_o && wb_we_i && wb_adr_i[7:2] == `MIS_IDX_MASK;
  assign clrAck = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == `MIS_IDX_CLRVIEW;
  // shadow of the mask, so irq checks need no internal probe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      maskSh  <= '0;
      supPrev <= 1'b0;
    end else begin
      supPrev <= supplyLow;
      if (supplyLow && !supPrev) begin
        maskSh <= '0;
      end else if (maskWr) begin
        maskSh <= (maskSh & ~lanes | wb_dat_i[19:0] & lanes) & `MIS_MASK_WR;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // only pulse-type flags may be masked here; others arrive late
  sequence clrQuiet;
    clrAck && (maskSh & 20'hff007) == 20'h0 &&
      !(|{sagEvent, crossTimeout, crossRise}) &&
      !$past(|{sagEvent, crossTimeout, crossRise});
  endsequence
  sequence holdLow;
    !irqN && !clrAck && !maskWr && !$past(maskWr) && !(supplyLow && !supPrev);
  endsequence
  ack_wait_a: assert property (busReq |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  sag_irq_a: assert property (
    |(sagEvent & maskSh[5:3]) && !maskWr && !rstEvt |=> !irqN)
    else $error("masked sag did not raise irq");
  timeout_irq_a: assert property (
    |(crossTimeout & maskSh[8:6]) && !maskWr && !rstEvt |=> !irqN)
    else $error("masked timeout did not raise irq");
  cross_irq_a: assert property (
    |(crossRise & maskSh[11:9]) && !maskWr && !rstEvt |=> !irqN)
    else $error("masked crossing did not raise irq");
  irq_quiet_a: assert property (
    maskSh == 20'h0 && $past(maskSh) == 20'h0 |-> irqN)
    else $error("irq low with all flags masked");
  sticky_irq_a: assert property (holdLow |=> !irqN)
    else $error("irq released without clearing read");
  clear_release_a: assert property (clrQuiet |=> irqN)
    else $error("clearing read did not release irq");
  reset_event_a: assert property ($rose(supplyLow) |=> irqN [*2])
    else $error("supply-low event left irq active");
endmodule : mis_status_flags_sva

bind mis_status_flags mis_status_flags_sva u_sva (
  .mclk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_ack_o, .irqN, .sagEvent, .crossTimeout, .crossRise,
  .supplyLow
);

// ### sim/tb.sv
// self-checking bench for the status flag block
`timescale 1ns/100ps
module tb;
  logic        mclk, reset_n, go, goWe, done, supplyLow, irqN;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        halfCycleTick, waveReady;
  logic [7:0]  goAdr, wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] goDat, rdData, wb_dat_i, wb_dat_o;
  logic [19:0] evt;
  logic [23:0] voltageSample, currentSample;
  logic [2:0]  sagEvent, crossTimeout, crossRise, activeSign, reactiveSign;
  logic [2:0]  activeBit14, reactiveBit14, apparentBit15;
  int          errors, compares;
  int          bits[10] = '{16, 11, 10, 9, 8, 7, 6, 5, 4, 3};
  // one pulse vector laid out like the flag word
  assign sagEvent      = evt[5:3];
  assign crossTimeout  = evt[8:6];
  assign crossRise     = evt[11:9];
  assign halfCycleTick = evt[12];
  assign waveReady     = evt[16];
  always #20 mclk = ~mclk;
  mis_status_flags DUT (.mclk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irqN, .sagEvent,
    .crossTimeout, .crossRise, .halfCycleTick, .supplyLow, .voltageSample,
    .currentSample, .waveReady, .activeSign, .reactiveSign, .activeBit14,
    .reactiveBit14, .apparentBit15);
  mis_mcu_model mcu (.mclk, .reset_n, .go, .goWe, .goAdr, .goDat, .done,
    .rdData, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_ack_o, .wb_dat_o);
  task print_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat);
    int n;
    @(posedge mclk);
    go    <= 1'b1;
    goWe  <= we;
    goAdr <= adr;
    goDat <= dat;
    @(posedge mclk);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 20) begin
      errors++;
      $display("ERROR %0t bus access hung", $time);
      print_verdict();
    end
  endtask : bus
  task automatic chk(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    compares++;
    if (rdData !== exp) begin
      errors++;
      $display("ERROR %0t adr %h got %h exp %h", $time, adr, rdData, exp);
    end
  endtask : chk
  task automatic chkIrq(input logic exp);
    @(negedge mclk);
    compares++;
    if (irqN !== exp) begin
      errors++;
      $display("ERROR %0t irq level %b exp %b", $time, irqN, exp);
    end
  endtask : chkIrq
  task automatic pulse(input int b);
    @(posedge mclk);
    evt <= 20'h1 << b;
    @(posedge mclk);
    evt <= 20'h0;
  endtask : pulse
  initial begin
    mclk = 0; reset_n = 0; go = 0; goWe = 0; goAdr = 0; goDat = 0;
    evt = 0; supplyLow = 0; voltageSample = 0; currentSample = 0;
    activeSign = 0; reactiveSign = 0; activeBit14 = 0; reactiveBit14 = 0;
    apparentBit15 = 0; errors = 0; compares = 0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    chk(8'h64, 32'h0);
    chk(8'h60, 32'h0);
    chk(8'h4c, 32'h7);
    chk(8'h70, 32'hffff);
    chk(8'h74, 32'hffffff);
    chk(8'h78, 32'hffffff);
    chk(8'h00, 32'h0);
    // crossings go C, B, A so no order error is provoked here
    foreach (bits[i]) begin
      pulse(bits[i]);
      pulse(bits[i]);
      chk(8'h64, 32'h1 << bits[i]);
      chk(8'h68, 32'h1 << bits[i]);
      chk(8'h64, 32'h0);
    end
    bus(1'b1, 8'h60, 32'hfffff);
    chk(8'h60, 32'hfdfff);
    bus(1'b1, 8'h60, 32'h8);
    pulse(6);
    chkIrq(1'b1);
    pulse(3);
    chkIrq(1'b0);
    chk(8'h64, 32'h48);
    chkIrq(1'b0);
    chk(8'h68, 32'h48);
    chkIrq(1'b1);
    bus(1'b1, 8'h74, 32'h100);
    bus(1'b1, 8'h78, 32'h200);
    @(posedge mclk) {voltageSample, currentSample} <= {24'h100, 24'h200};
    chk(8'h64, 32'h0);
    @(posedge mclk) voltageSample <= 24'h101;
    chk(8'h64, 32'h4000);
    @(posedge mclk) {voltageSample, currentSample} <= {24'h0, 24'h201};
    chk(8'h68, 32'hc000);
    @(posedge mclk) currentSample <= 24'h0;
    chk(8'h68, 32'h8000);
    chk(8'h64, 32'h0);
    bus(1'b1, 8'h4c, 32'h1);
    @(posedge mclk) {activeSign, reactiveSign} <= {3'h2, 3'h4};
    chk(8'h64, 32'h0);
    @(posedge mclk) activeSign <= 3'h3;
    chk(8'h68, 32'h20000);
    @(posedge mclk) reactiveSign <= 3'h5;
    chk(8'h68, 32'h40000);
    @(posedge mclk) activeBit14 <= 3'h4;
    chk(8'h68, 32'h1);
    @(posedge mclk) reactiveBit14 <= 3'h1;
    chk(8'h68, 32'h2);
    @(posedge mclk) apparentBit15 <= 3'h2;
    chk(8'h68, 32'h4);
    @(posedge mclk) apparentBit15 <= 3'h0;
    chk(8'h64, 32'h0);
    bus(1'b1, 8'h70, 32'h3);
    bus(1'b1, 8'h4c, 32'h9);
    pulse(12);
    pulse(12);
    chk(8'h64, 32'h0);
    pulse(12);
    chk(8'h68, 32'h1000);
    bus(1'b1, 8'h60, 32'hfc8);
    pulse(9);
    pulse(10);
    pulse(7);
    chkIrq(1'b0);
    chk(8'h68, 32'h80680);
    chkIrq(1'b1);
    pulse(11);
    pulse(9);
    pulse(11);
    chk(8'h68, 32'h0a00);
    bus(1'b1, 8'h60, 32'hfffff);
    @(posedge mclk) supplyLow <= 1'b1;
    chk(8'h60, 32'h0);
    chk(8'h64, 32'h0);
    chk(8'h4c, 32'h7);
    print_verdict();
  end
endmodule : tb
